/* common/rxpam_pkg.sv */
package rxpam_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [15:0] RXPAM_OFS_PKT_CTRL0 = 16'h0502;
    localparam logic [15:0] RXPAM_OFS_CELL_ADDR = 16'h0513;
    localparam logic [15:0] RXPAM_OFS_CELL_NUM = 16'h0517;

    // ****************************************************************
    // field layout
    // ****************************************************************
    localparam int RXPAM_SEL_W = 5;
    localparam int RXPAM_SEL_LSB = 0;
    localparam int RXPAM_CHAN_W = 2;
    localparam int RXPAM_CHAN_LSB = 0;
    localparam int RXPAM_FILL_W = 5;
    localparam int RXPAM_REG_W = 8;

    // ****************************************************************
    // reset, empty-fill and default channel values
    // ****************************************************************
    localparam logic [4:0] RXPAM_SEL_RESET = 5'h00;
    localparam logic [4:0] RXPAM_FILL_EMPTY = 5'h00;
    localparam logic [1:0] RXPAM_CHAN_DEFAULT = 2'h0;

    // ****************************************************************
    // operating modes of the receive interface
    // ****************************************************************
    typedef enum logic [1:0] {
        RXPAM_MODE_CELL = 2'h0,
        RXPAM_MODE_PKT = 2'h1,
        RXPAM_MODE_CLEAR = 2'h2,
        RXPAM_MODE_HDLC = 2'h3
    } rxpam_mode_t;

endpackage : rxpam_pkg

/* core/rxpam_match.sv */
// Function
// - sample cell address on each cell clock rise
// - compare cell address with configured port identity
// - match and enable drive cell available from fill
// - cell address mismatch keeps cell available floating
// - cell address used only in multi-port setups
// - sample packet address on each packet clock rise
// - compare packet address with control byte zero
// - match and enable drive packet available from fill
// - packet address mismatch keeps packet available floating
module rxpam_match
    import rxpam_pkg::*;
#(
    parameter logic [1:0] CHANNEL_INDEX = RXPAM_CHAN_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] link_mode,
    input wire logic multi_port,
    input wire logic [7:0] rx_packet_control_byte0,
    input wire logic [7:0] rx_cell_port_address,
    input wire logic [7:0] rx_cell_port_number,
    input wire logic [4:0] receive_buffer_fill,
    input wire logic cell_rx_clock,
    input wire logic pkt_rx_clock,
    input wire logic [4:0] rx_port_select_pins,
    input wire logic cell_rx_enable_n,
    input wire logic pkt_rx_enable_n,
    output logic cell_available,
    output logic cell_available_oe,
    output logic pkt_available,
    output logic pkt_available_oe
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic cclk_s1;
        logic cclk_s2;
        logic cclk_d;
        logic pclk_s1;
        logic pclk_s2;
        logic pclk_d;
        logic [4:0] sel_s1;
        logic [4:0] sel_s2;
        logic cen_n_s1;
        logic cen_n_s2;
        logic pen_n_s1;
        logic pen_n_s2;
        logic cell_oe;
        logic cell_val;
        logic pkt_oe;
        logic pkt_val;
    } rxpam_state_t;

    localparam rxpam_state_t RXPAM_STATE_RESET = '{
        cclk_s1: 1'b0,
        cclk_s2: 1'b0,
        cclk_d: 1'b0,
        pclk_s1: 1'b0,
        pclk_s2: 1'b0,
        pclk_d: 1'b0,
        sel_s1: RXPAM_SEL_RESET,
        sel_s2: RXPAM_SEL_RESET,
        cen_n_s1: 1'b1,
        cen_n_s2: 1'b1,
        pen_n_s1: 1'b1,
        pen_n_s2: 1'b1,
        cell_oe: 1'b0,
        cell_val: 1'b0,
        pkt_oe: 1'b0,
        pkt_val: 1'b0
    };

    rxpam_state_t q;
    rxpam_state_t next_q;

    // ****************************************************************
    // decoding
    // ****************************************************************
    function automatic logic sel_match(
        input logic [4:0] sampled,
        input logic [4:0] identity
    );
        sel_match = (sampled == identity);
    endfunction : sel_match

    function automatic logic has_data(input logic [4:0] fill);
        has_data = (fill != RXPAM_FILL_EMPTY);
    endfunction : has_data

    logic cell_edge;
    logic pkt_edge;
    logic cell_mode;
    logic pkt_mode;
    logic cell_hit;
    logic pkt_hit;
    logic [4:0] cell_identity;
    logic [4:0] pkt_identity;
    logic chan_ok;

    assign cell_edge = q.cclk_s2 && !q.cclk_d;
    assign pkt_edge = q.pclk_s2 && !q.pclk_d;
    assign cell_mode = (link_mode == RXPAM_MODE_CELL);
    assign pkt_mode = (link_mode == RXPAM_MODE_PKT);
    assign cell_identity =
        rx_cell_port_address[RXPAM_SEL_LSB +: RXPAM_SEL_W];
    assign pkt_identity =
        rx_packet_control_byte0[RXPAM_SEL_LSB +: RXPAM_SEL_W];
    assign chan_ok = (rx_cell_port_number[RXPAM_CHAN_LSB +: RXPAM_CHAN_W]
        == CHANNEL_INDEX);
    // single-port setups ignore the pins for cell polls only and always hit
    assign cell_hit = !multi_port ||
        (sel_match(q.sel_s2, cell_identity) && chan_ok);
    assign pkt_hit = sel_match(q.sel_s2, pkt_identity);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_q = q;
        next_q.cclk_s1 = cell_rx_clock;
        next_q.cclk_s2 = q.cclk_s1;
        next_q.cclk_d = q.cclk_s2;
        next_q.pclk_s1 = pkt_rx_clock;
        next_q.pclk_s2 = q.pclk_s1;
        next_q.pclk_d = q.pclk_s2;
        next_q.sel_s1 = rx_port_select_pins;
        next_q.sel_s2 = q.sel_s1;
        next_q.cen_n_s1 = cell_rx_enable_n;
        next_q.cen_n_s2 = q.cen_n_s1;
        next_q.pen_n_s1 = pkt_rx_enable_n;
        next_q.pen_n_s2 = q.pen_n_s1;
        if (!cell_mode) begin
            next_q.cell_oe = 1'b0;
        end else if (cell_edge) begin
            if (!cell_hit) begin
                next_q.cell_oe = 1'b0;
            end else if (!q.cen_n_s2) begin
                next_q.cell_oe = 1'b1;
                next_q.cell_val = has_data(receive_buffer_fill);
            end
        end
        if (!pkt_mode) begin
            next_q.pkt_oe = 1'b0;
        end else if (pkt_edge) begin
            if (!pkt_hit) begin
                next_q.pkt_oe = 1'b0;
            end else if (!q.pen_n_s2) begin
                next_q.pkt_oe = 1'b1;
                next_q.pkt_val = has_data(receive_buffer_fill);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= RXPAM_STATE_RESET;
        end else begin
            q <= next_q;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign cell_available = q.cell_val;
    assign cell_available_oe = q.cell_oe;
    assign pkt_available = q.pkt_val;
    assign pkt_available_oe = q.pkt_oe;

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence cell_poll_s;
        cell_mode && q.cclk_s2 && !q.cclk_d;
    endsequence

    sequence pkt_poll_s;
        pkt_mode && q.pclk_s2 && !q.pclk_d;
    endsequence

    sequence cell_match_s;
        cell_poll_s ##0 (multi_port && q.sel_s2 == cell_identity
            && chan_ok && !q.cen_n_s2);
    endsequence

    sequence pkt_match_s;
        pkt_poll_s ##0 (q.sel_s2 == pkt_identity && !q.pen_n_s2);
    endsequence

    property cell_drive_p;
        @(posedge clk) disable iff (rst)
        cell_match_s |=> cell_available_oe &&
            cell_available == ($past(receive_buffer_fill) != 5'h00);
    endproperty

    property pkt_drive_p;
        @(posedge clk) disable iff (rst)
        pkt_match_s |=> pkt_available_oe &&
            pkt_available == ($past(receive_buffer_fill) != 5'h00);
    endproperty

    cell_drive_a: assert property (cell_drive_p)
        else $error("cell available not driven on a match");

    pkt_drive_a: assert property (pkt_drive_p)
        else $error("packet available not driven on a match");

    cell_mismatch_hiz_a: assert property (
        @(posedge clk) disable iff (rst)
        cell_poll_s ##0 (multi_port && q.sel_s2 != cell_identity)
        |=> !cell_available_oe)
        else $error("cell available driven on address mismatch");

    pkt_mismatch_hiz_a: assert property (
        @(posedge clk) disable iff (rst)
        pkt_poll_s ##0 (q.sel_s2 != pkt_identity)
        |=> !pkt_available_oe)
        else $error("packet available driven on address mismatch");

    cell_single_port_a: assert property (
        @(posedge clk) disable iff (rst)
        cell_poll_s ##0 (!multi_port && !q.cen_n_s2)
        |=> cell_available_oe)
        else $error("single-port poll left cell available floating");

    cell_edge_only_a: assert property (
        @(posedge clk) disable iff (rst)
        !(q.cclk_s2 && !q.cclk_d) && cell_mode
        |=> $stable(cell_available_oe) && $stable(cell_available))
        else $error("cell available moved without a cell clock rise");

    pkt_edge_only_a: assert property (
        @(posedge clk) disable iff (rst)
        !(q.pclk_s2 && !q.pclk_d) && pkt_mode
        |=> $stable(pkt_available_oe) && $stable(pkt_available))
        else $error("packet available moved without a packet clock rise");

    cell_port_number_a: assert property (
        @(posedge clk) disable iff (rst)
        cell_poll_s ##0 (multi_port && !chan_ok)
        |=> !cell_available_oe)
        else $error("cell available driven for another port number");

    pkt_identity_src_a: assert property (
        @(posedge clk) disable iff (rst)
        $rose(pkt_available_oe) |->
            $past(q.sel_s2) == $past(pkt_identity))
        else $error("packet available rose without identity match");

    reset_float_a: assert property (
        @(posedge clk)
        rst |=> !cell_available_oe && !pkt_available_oe)
        else $error("available outputs driven after reset");

    first_drive_a: assert property (
        @(posedge clk) disable iff (rst)
        $rose(cell_available_oe) |-> !$past(q.cen_n_s2) && $past(cell_mode))
        else $error("cell available driven without enable");

    mode_off_a: assert property (
        @(posedge clk) disable iff (rst)
        (link_mode == RXPAM_MODE_CLEAR || link_mode == RXPAM_MODE_HDLC)
        |=> !cell_available_oe && !pkt_available_oe)
        else $error("available driven in framer or hdlc mode");

    cell_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        cell_poll_s ##0 (multi_port && q.sel_s2 == cell_identity
            && chan_ok && q.cen_n_s2)
        |=> $stable(cell_available_oe) && $stable(cell_available))
        else $error("cell available changed with enable high");

    pkt_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        pkt_poll_s ##0 (q.sel_s2 == pkt_identity && q.pen_n_s2)
        |=> $stable(pkt_available_oe) && $stable(pkt_available))
        else $error("packet available changed with enable high");

    single_port_value_a: assert property (
        @(posedge clk) disable iff (rst)
        cell_poll_s ##0 (!multi_port && !q.cen_n_s2)
        |=> cell_available ==
            ($past(receive_buffer_fill) != RXPAM_FILL_EMPTY))
        else $error("single-port poll gave a wrong cell available");

    cell_identity_src_a: assert property (
        @(posedge clk) disable iff (rst)
        $rose(cell_available_oe) && $past(multi_port) |->
            $past(q.sel_s2) == $past(cell_identity) && $past(chan_ok))
        else $error("cell available rose without identity match");

    pkt_first_drive_a: assert property (
        @(posedge clk) disable iff (rst)
        $rose(pkt_available_oe) |-> !$past(q.pen_n_s2) && $past(pkt_mode))
        else $error("packet available driven without enable");

    cell_mode_only_a: assert property (
        @(posedge clk) disable iff (rst)
        !cell_mode |=> !cell_available_oe)
        else $error("cell available driven outside cell mode");

    pkt_mode_only_a: assert property (
        @(posedge clk) disable iff (rst)
        !pkt_mode |=> !pkt_available_oe)
        else $error("packet available driven outside packet mode");

endmodule : rxpam_match

/* verif/rxpam_llp.sv */
// ******
// link layer processor model
// ******
module rxpam_llp
    import rxpam_pkg::*;
(
    input wire logic clk,
    output logic cell_rx_clock,
    output logic pkt_rx_clock,
    output logic [4:0] rx_port_select_pins,
    output logic cell_rx_enable_n,
    output logic pkt_rx_enable_n
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        cell_rx_clock = 1'b0;
        pkt_rx_clock = 1'b0;
        rx_port_select_pins = RXPAM_SEL_RESET;
        cell_rx_enable_n = 1'b1;
        pkt_rx_enable_n = 1'b1;
    end

    // one poll: address set up, one 40 ns link clock pulse, then idle
    task automatic poll(input logic pkt, input logic [4:0] sel,
                        input logic en_n);
        @(posedge clk);
        rx_port_select_pins <= sel;
        cell_rx_enable_n <= pkt | en_n;
        pkt_rx_enable_n <= ~pkt | en_n;
        repeat (4) @(posedge clk);
        cell_rx_clock <= ~pkt;
        pkt_rx_clock <= pkt;
        repeat (8) @(posedge clk);
        cell_rx_clock <= 1'b0;
        pkt_rx_clock <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : poll
endmodule : rxpam_llp

/* verif/tb_rxpam_match.sv */
module tb_rxpam_match
    import rxpam_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] mode = RXPAM_MODE_CELL;
    logic mp = 1'b1;
    logic [7:0] ctrl0 = 8'h00;
    logic [7:0] caddr = 8'h0A;
    logic [7:0] cnum = 8'h00;
    logic [4:0] fill = 5'h03;
    logic cclk, pclk, cen_n, pen_n, cav, coe, pav, poe;
    logic [4:0] pins;
    int error_cnt = 0;
    int n_checks = 0;
    int cycles = 0;

    always #2.5 clk = ~clk;

    rxpam_llp u_rxpam_llp (.clk(clk), .cell_rx_clock(cclk),
        .pkt_rx_clock(pclk), .rx_port_select_pins(pins),
        .cell_rx_enable_n(cen_n), .pkt_rx_enable_n(pen_n));

    rxpam_match u_rxpam_match (.clk(clk), .rst(rst), .link_mode(mode),
        .multi_port(mp), .rx_packet_control_byte0(ctrl0),
        .rx_cell_port_address(caddr), .rx_cell_port_number(cnum),
        .receive_buffer_fill(fill), .cell_rx_clock(cclk),
        .pkt_rx_clock(pclk), .rx_port_select_pins(pins),
        .cell_rx_enable_n(cen_n), .pkt_rx_enable_n(pen_n),
        .cell_available(cav), .cell_available_oe(coe),
        .pkt_available(pav), .pkt_available_oe(poe));

    // ******
    // checks and scenarios
    // ******
    task automatic chk(input logic [3:0] exp);
        logic [3:0] seen;
        seen = {coe, coe & cav, poe, poe & pav};
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR outputs expected %b seen %b", exp, seen);
        end
    endtask : chk

    task automatic t_reset();
        chk(4'b0000);
        u_rxpam_llp.poll(1'b0, 5'h0A, 1'b1);
        chk(4'b0000);
    endtask : t_reset

    task automatic t_cell();
        u_rxpam_llp.poll(1'b0, 5'h0A, 1'b0);
        chk(4'b1100);
        fill <= 5'h00;
        u_rxpam_llp.poll(1'b0, 5'h0A, 1'b0);
        chk(4'b1000);
        fill <= 5'h1F;
        u_rxpam_llp.poll(1'b0, 5'h0A, 1'b1);
        chk(4'b1000);
        u_rxpam_llp.poll(1'b0, 5'h0B, 1'b0);
        chk(4'b0000);
        cnum <= 8'h01;
        u_rxpam_llp.poll(1'b0, 5'h0A, 1'b0);
        chk(4'b0000);
        cnum <= 8'h00;
        caddr <= 8'h1F;
        u_rxpam_llp.poll(1'b0, 5'h1F, 1'b0);
        chk(4'b1100);
    endtask : t_cell

    task automatic t_single();
        mp <= 1'b0;
        u_rxpam_llp.poll(1'b0, 5'h00, 1'b0);
        chk(4'b1100);
        mp <= 1'b1;
    endtask : t_single

    task automatic t_pkt();
        mode <= RXPAM_MODE_PKT;
        ctrl0 <= 8'h13;
        caddr <= 8'h13;
        u_rxpam_llp.poll(1'b1, 5'h13, 1'b0);
        chk(4'b0011);
        u_rxpam_llp.poll(1'b1, 5'h12, 1'b0);
        chk(4'b0000);
        fill <= 5'h00;
        u_rxpam_llp.poll(1'b1, 5'h13, 1'b0);
        chk(4'b0010);
    endtask : t_pkt

    task automatic t_rerun();
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(4'b0000);
        u_rxpam_llp.poll(1'b1, 5'h13, 1'b1);
        chk(4'b0000);
    endtask : t_rerun

    task automatic t_quiet();
        fill <= 5'h07;
        ctrl0 <= 8'h00;
        caddr <= 8'h00;
        for (int m = 2; m < 4; m++) begin
            mode <= 2'(m);
            u_rxpam_llp.poll(1'b0, 5'h00, 1'b0);
            u_rxpam_llp.poll(1'b1, 5'h00, 1'b0);
            chk(4'b0000);
        end
    endtask : t_quiet

    task automatic results();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            results();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_cell();
        t_single();
        t_pkt();
        t_rerun();
        t_quiet();
        results();
    end
endmodule : tb_rxpam_match
